// File: core/efc_flash_ctrl.v
// Flash controller: bus slave, registers, command walker, protection
`timescale 1ns/1ps
`default_nettype none
`include "efc_consts.vh"
module efc_flash_ctrl #(
    parameter PAGES = 80,
    parameter ROWS = 8,
    parameter WORDS = 64
) (
    input wire mclk,
    input wire reset,
    input wire hselReg,
    input wire hselArray,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire coreHalted,
    input wire debugAccess,
    output wire ramDebugBlock
);
    // Whole array depth
    localparam DEPTH = PAGES * ROWS * WORDS;
    // Walker states, one-hot
    localparam S_IDLE = 4'h1;
    localparam S_RD = 4'h2;
    localparam S_WR = 4'h4;
    localparam S_FIN = 4'h8;

    // ************************************************************
    // Declarations
    // ************************************************************
    reg [3:0] state_q; // Walker state
    reg [7:0] opCode_q; // Operation being walked
    reg [15:0] cur_q; // Current word index
    reg [15:0] last_q; // Final word index
    reg [1:0] quadIdx_q; // Quad data selector
    reg [31:0] signature_q; // Scan signature
    reg allMatch_q; // Every scanned word matched so far
    reg [31:0] protLo_q; // Shadow of first protection word
    reg [31:0] protHi_q; // Shadow of second protection word
    reg [7:0] command_q; // Last command code written
    reg [31:0] config_q; // Plain storage
    reg [31:0] progAddr_q; // program_address register
    reg [31:0] burstWordFirst_q; // Data word 0, also pattern
    reg [31:0] burstWord1_q;
    reg [31:0] burstWord2_q;
    reg [31:0] burstWord3_q;
    reg [`EFC_FLG_W-1:0] rawFlags_q; // Unmasked status
    reg [`EFC_FLG_W-1:0] enable_q; // Per-flag mask
    reg phase1_q; // Data phase, wait state
    reg phase2_q; // Data phase, final cycle
    reg arrIssued_q; // Array read issued last cycle
    reg isArr_q; // Captured access targets array
    reg isWr_q; // Captured access is a write
    reg blockRd_q; // Captured read must return zero
    reg err_q; // Captured access gets error answer
    reg [15:0] busAddr_q; // Captured word or register address
    reg [31:0] hrdata_q; // Read data to the bus
    reg [31:0] regRead; // Register read mux
    reg [31:0] pattern; // Data word for programming
    wire [31:0] memRdata;
    wire [31:0] sigNext;
    wire stIdle = state_q[0];
    wire stRd = state_q[1];
    wire stWr = state_q[2];
    wire stFin = state_q[3];

    // ************************************************************
    // Protection decode
    // ************************************************************
    // Any bit cleared in either word arms protection
    wire protOn = ~((protLo_q == `EFC_RST_ONES) &&
                    (protHi_q == `EFC_RST_ONES));
    assign ramDebugBlock = protOn;
    wire lockNow = protOn & coreHalted;

    // ************************************************************
    // Bus address phase
    // ************************************************************
    wire addrPhase = hready & htrans[1] & (hselReg | hselArray);
    // Debugger read of a locked array gets the error answer
    wire errNow = hselArray & ~hwrite & lockNow & debugAccess;
    // Array reads wait for the walker to be idle
    wire arrIssue = phase1_q & isArr_q & ~isWr_q & ~arrIssued_q & stIdle;
    wire done1 = ~isArr_q | isWr_q | arrIssued_q;
    wire regWr = phase1_q & ~isArr_q & isWr_q;
    assign hreadyout = ~phase1_q;
    // Error only in the final two cycles
    assign hresp = err_q & (arrIssued_q | phase2_q);
    assign hrdata = hrdata_q;

    // ************************************************************
    // Bus phase tracking
    // ************************************************************
    always @(posedge mclk) begin
        if (reset) begin
            phase1_q <= 1'b0;
            phase2_q <= 1'b0;
            arrIssued_q <= 1'b0;
            isArr_q <= 1'b0;
            isWr_q <= 1'b0;
            blockRd_q <= 1'b0;
            err_q <= 1'b0;
            busAddr_q <= 16'h0000;
        end else begin
            phase2_q <= phase1_q & done1;
            arrIssued_q <= arrIssue;
            if (addrPhase) begin
                // New transfer captured
                phase1_q <= 1'b1;
                isArr_q <= hselArray;
                isWr_q <= hwrite;
                blockRd_q <= lockNow;
                err_q <= errNow;
                busAddr_q <= hselArray ?
                    haddr[`EFC_WADDR_MSB:`EFC_WADDR_LSB] :
                    {8'h00, haddr[7:0]};
            end else if (phase1_q && done1) begin
                phase1_q <= 1'b0;
            end else if (phase2_q) begin
                // Error answer ends with the final cycle
                err_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Register read mux, reserved bits read as zero
    // ************************************************************
    always @* begin
        regRead = `EFC_RST_ZERO;
        if (busAddr_q[7:0] == `EFC_OFS_COMMAND) begin
            regRead = {24'h000000, command_q};
        end else if (busAddr_q[7:0] == `EFC_OFS_CONFIG) begin
            regRead = config_q;
        end else if (busAddr_q[7:0] == `EFC_OFS_STATUS) begin
            regRead = {26'h0, rawFlags_q & enable_q};
        end else if (busAddr_q[7:0] == `EFC_OFS_ENABLE) begin
            regRead = {26'h0, enable_q};
        end else if (busAddr_q[7:0] == `EFC_OFS_RAW) begin
            regRead = {26'h0, rawFlags_q};
        end else if (busAddr_q[7:0] == `EFC_OFS_PADDR) begin
            regRead = progAddr_q;
        end else if (busAddr_q[7:0] == `EFC_OFS_SIGN) begin
            regRead = signature_q;
        end else if (busAddr_q[7:0] == `EFC_OFS_BURST_WORD_FIRST) begin
            regRead = burstWordFirst_q;
        end else if (busAddr_q[7:0] == `EFC_OFS_DATA1) begin
            regRead = burstWord1_q;
        end else if (busAddr_q[7:0] == `EFC_OFS_DATA2) begin
            regRead = burstWord2_q;
        end else if (busAddr_q[7:0] == `EFC_OFS_DATA3) begin
            regRead = burstWord3_q;
        end
    end

    // ************************************************************
    // Read data register
    // ************************************************************
    always @(posedge mclk) begin
        if (reset) begin
            hrdata_q <= `EFC_RST_ZERO;
        end else if (arrIssued_q) begin
            // Locked while halted: fixed zero
            hrdata_q <= blockRd_q ? `EFC_RST_ZERO : memRdata;
        end else if (phase1_q && !isArr_q && !isWr_q) begin
            hrdata_q <= regRead;
        end
    end

    // ************************************************************
    // Command decode
    // ************************************************************
    wire cmdWr = regWr && (busAddr_q[7:0] == `EFC_OFS_COMMAND);
    wire [7:0] code = hwdata[7:0];
    wire codeOk = (hwdata[31:8] == 24'h0) &&
                  ((code == `EFC_CMD_PAGE_ERASE) ||
                   (code == `EFC_CMD_CLEAR) ||
                   (code == `EFC_CMD_WRITE) ||
                   (code == `EFC_CMD_FILL) ||
                   (code == `EFC_CMD_SCAN) ||
                   (code == `EFC_CMD_QUAD));
    // Only an idle walker takes a legal code
    wire launch = cmdWr & stIdle & codeOk;
    wire collide = cmdWr & ~stIdle;
    wire badCode = cmdWr & stIdle & ~codeOk;
    wire isScan = (opCode_q == `EFC_CMD_SCAN);
    wire isBoot = (opCode_q == `EFC_CMD_BOOT);
    wire isErase = (opCode_q == `EFC_CMD_PAGE_ERASE) ||
                   (opCode_q == `EFC_CMD_CLEAR);

    // ************************************************************
    // Programming data selection
    // ************************************************************
    always @* begin
        pattern = burstWordFirst_q; // Single and fill use word 0
        if (opCode_q == `EFC_CMD_QUAD) begin
            case (quadIdx_q)
                2'd1: pattern = burstWord1_q;
                2'd2: pattern = burstWord2_q;
                2'd3: pattern = burstWord3_q;
                default: pattern = burstWordFirst_q;
            endcase
        end
    end

    // Erase writes ones; programming can only pull bits low
    wire [31:0] wrWord = isErase ? `EFC_RST_ONES :
                         (memRdata & pattern);
    wire memWr = stWr & ~isScan & ~isBoot;
    wire memRd = arrIssue | stRd;
    wire [15:0] memAddr = stIdle ? busAddr_q : cur_q;

    // Signature step: shift, polynomial feedback, fold in word
    assign sigNext = {signature_q[30:0], 1'b0} ^
                     (signature_q[31] ? `EFC_POLY : `EFC_RST_ZERO) ^
                     memRdata;

    // ************************************************************
    // Software registers
    // ************************************************************
    always @(posedge mclk) begin
        if (reset) begin
            command_q <= 8'h00;
            config_q <= `EFC_RST_ZERO;
            progAddr_q <= `EFC_RST_ZERO;
            burstWordFirst_q <= `EFC_RST_ONES;
            burstWord1_q <= `EFC_RST_ONES;
            burstWord2_q <= `EFC_RST_ONES;
            burstWord3_q <= `EFC_RST_ONES;
            enable_q <= `EFC_RST_ENABLE;
        end else if (regWr) begin
            if (busAddr_q[7:0] == `EFC_OFS_COMMAND) begin
                command_q <= code;
            end else if (busAddr_q[7:0] == `EFC_OFS_CONFIG) begin
                config_q <= hwdata;
            end else if (busAddr_q[7:0] == `EFC_OFS_ENABLE) begin
                enable_q <= hwdata[`EFC_FLG_W-1:0];
            end else if (busAddr_q[7:0] == `EFC_OFS_PADDR) begin
                progAddr_q <= hwdata;
            end else if (busAddr_q[7:0] == `EFC_OFS_BURST_WORD_FIRST) begin
                burstWordFirst_q <= hwdata;
            end else if (busAddr_q[7:0] == `EFC_OFS_DATA1) begin
                burstWord1_q <= hwdata;
            end else if (busAddr_q[7:0] == `EFC_OFS_DATA2) begin
                burstWord2_q <= hwdata;
            end else if (busAddr_q[7:0] == `EFC_OFS_DATA3) begin
                burstWord3_q <= hwdata;
            end
        end
    end

    // ************************************************************
    // Status flags: hardware set wins over write-one clear
    // ************************************************************
    wire clrHit = regWr && ((busAddr_q[7:0] == `EFC_OFS_STATUS) ||
                            (busAddr_q[7:0] == `EFC_OFS_RAW));
    wire [`EFC_FLG_W-1:0] clrMask = clrHit ? hwdata[`EFC_FLG_W-1:0] :
                                    {`EFC_FLG_W{1'b0}};
    wire finOp = stFin & ~isBoot;
    wire [`EFC_FLG_W-1:0] setMask = {1'b0,
        finOp & isScan & allMatch_q,
        badCode, collide,
        launch,
        finOp};
    always @(posedge mclk) begin
        if (reset) begin
            rawFlags_q <= {`EFC_FLG_W{1'b0}};
        end else begin
            rawFlags_q <= (rawFlags_q & ~clrMask) | setMask;
        end
    end

    // ************************************************************
    // Command walker: read each word, then act on it
    // ************************************************************
    // Reset starts a walk over the protection words to load shadows
    always @(posedge mclk) begin
        if (reset) begin
            state_q <= S_RD;
            opCode_q <= `EFC_CMD_BOOT;
            cur_q <= `EFC_PROT_LO;
            last_q <= `EFC_LAST_WORD;
            quadIdx_q <= 2'd0;
            signature_q <= `EFC_RST_ONES;
            allMatch_q <= 1'b1;
            protLo_q <= `EFC_RST_ONES;
            protHi_q <= `EFC_RST_ONES;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (launch) begin
                        opCode_q <= code;
                        quadIdx_q <= 2'd0;
                        state_q <= S_RD;
                        if (code == `EFC_CMD_PAGE_ERASE) begin
                            // Page in bits 15:9, rows and words span
                            cur_q <= {progAddr_q[`EFC_PAGE_MSB:`EFC_PAGE_LSB],
                                      9'h000};
                            last_q <= {progAddr_q[`EFC_PAGE_MSB:`EFC_PAGE_LSB],
                                       `EFC_PAGE_SPAN};
                        end else if (code == `EFC_CMD_WRITE) begin
                            cur_q <= progAddr_q[15:0];
                            last_q <= progAddr_q[15:0];
                        end else if (code == `EFC_CMD_QUAD) begin
                            cur_q <= progAddr_q[15:0];
                            last_q <= progAddr_q[15:0] + `EFC_QUAD_SPAN;
                        end else begin
                            // Clear, fill and scan cover the array
                            cur_q <= 16'h0000;
                            last_q <= `EFC_LAST_WORD;
                        end
                        if (code == `EFC_CMD_SCAN) begin
                            signature_q <= `EFC_RST_ONES;
                            allMatch_q <= 1'b1;
                        end
                    end
                end
                S_RD: begin
                    state_q <= S_WR;
                end
                S_WR: begin
                    if (isScan) begin
                        signature_q <= sigNext;
                        if (memRdata != burstWordFirst_q) begin
                            allMatch_q <= 1'b0;
                        end
                    end
                    // Shadows follow boot reads and array writes
                    if ((isBoot || memWr) && (cur_q == `EFC_PROT_LO)) begin
                        protLo_q <= isBoot ? memRdata : wrWord;
                    end
                    if ((isBoot || memWr) && (cur_q == `EFC_LAST_WORD)) begin
                        protHi_q <= isBoot ? memRdata : wrWord;
                    end
                    quadIdx_q <= quadIdx_q + 2'd1;
                    if (cur_q == last_q) begin
                        state_q <= S_FIN;
                    end else begin
                        cur_q <= cur_q + 16'h0001;
                        state_q <= S_RD;
                    end
                end
                S_FIN: begin
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Array storage
    // ************************************************************
    efc_flash_mem #(
        .WIDTH(32),
        .DEPTH(DEPTH),
        .AW(16)
    ) uArray (
        .clk(mclk),
        .rdEn(memRd),
        .wrEn(memWr),
        .addr(memAddr),
        .wdata(wrWord),
        .rdata_q(memRdata)
    );
endmodule // efc_flash_ctrl
`default_nettype wire

// File: core/efc_consts.vh
// Shared constants for the embedded flash controller
// Operation
// - Code 0x11 page erase, 0x22 array clear
// - 0x33 one word, 0x44 fill, 0xCC quad
// - Code 0x55 scans array: compare and signature
// - 80 pages x 8 rows x 64 words
// - Address: page, row, then word select
// - Programming only clears bits to zero
// - Page erase leaves the page all ones
// - Array clear leaves whole array all ones
// - Accepted flag raised, cleared by writing one
// - Finished flag raised, cleared by writing one
// - Match flag only when every word matches
// - Signature over all words, all-ones seed
// - Quad program writes four consecutive words
// - Fill programs every word with one value
// - Plain 32-bit reads like ordinary memory
// - Protected and halted: zero, debugger error
// - Protection also blocks debug access to RAM
// - Protected unless last two words all ones
// - Command while busy sets collision flag
// - Unknown code sets bad code flag
// - Raw and masked status, mask resets 0x3F
`ifndef EFC_CONSTS_VH
`define EFC_CONSTS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define EFC_OFS_COMMAND 8'h00
`define EFC_OFS_CONFIG 8'h04
`define EFC_OFS_STATUS 8'h08
`define EFC_OFS_ENABLE 8'h0C
`define EFC_OFS_RAW 8'h10
`define EFC_OFS_PADDR 8'h18
`define EFC_OFS_SIGN 8'h24
`define EFC_OFS_BURST_WORD_FIRST 8'h40
`define EFC_OFS_DATA1 8'h44
`define EFC_OFS_DATA2 8'h48
`define EFC_OFS_DATA3 8'h4C

// ****************************************************************
// Command codes
// ****************************************************************
`define EFC_CMD_PAGE_ERASE 8'h11
`define EFC_CMD_CLEAR 8'h22
`define EFC_CMD_WRITE 8'h33
`define EFC_CMD_FILL 8'h44
`define EFC_CMD_SCAN 8'h55
`define EFC_CMD_QUAD 8'hCC
`define EFC_CMD_BOOT 8'h00

// ****************************************************************
// Status flag positions
// ****************************************************************
`define EFC_FLG_DONE 0
`define EFC_FLG_START 1
`define EFC_FLG_COLL 2
`define EFC_FLG_BAD 3
`define EFC_FLG_MATCH 4
`define EFC_FLG_NRDY 5
`define EFC_FLG_W 6

// ****************************************************************
// Reset values and array geometry
// ****************************************************************
`define EFC_RST_ENABLE 6'h3F
`define EFC_RST_ONES 32'hFFFFFFFF
`define EFC_RST_ZERO 32'h00000000
`define EFC_POLY 32'h8000001B
`define EFC_LAST_WORD 16'h9FFF
`define EFC_PROT_LO 16'h9FFE
`define EFC_PAGE_MSB 15
`define EFC_PAGE_LSB 9
`define EFC_PAGE_SPAN 9'h1FF
`define EFC_QUAD_SPAN 16'h0003
`define EFC_WADDR_MSB 17
`define EFC_WADDR_LSB 2

`endif

// File: core/efc_flash_mem.v
// Flash array storage with a registered read port
`timescale 1ns/1ps
`default_nettype none
module efc_flash_mem #(
    parameter WIDTH = 32,
    parameter DEPTH = 40960,
    parameter AW = 16
) (
    input wire clk,
    input wire rdEn,
    input wire wrEn,
    input wire [AW-1:0] addr,
    input wire [WIDTH-1:0] wdata,
    output reg [WIDTH-1:0] rdata_q
);
    // Storage cells
    reg [WIDTH-1:0] cells [0:DEPTH-1];
    // Address falls inside the populated array
    wire inRange = ({1'b0, addr} < DEPTH);

    // ************************************************************
    // Single port: write or read, one word per cycle
    // ************************************************************
    always @(posedge clk) begin
        if (wrEn && inRange) begin
            cells[addr] <= wdata;
        end
        if (rdEn) begin
            // Unpopulated space reads as erased
            rdata_q <= inRange ? cells[addr] : {WIDTH{1'b1}};
        end
    end
endmodule // efc_flash_mem
`default_nettype wire

// File: verification/efc_props.sv
// Bus port checker for the flash controller
`timescale 1ns/1ps
`default_nettype none
module efc_props (
    input wire logic mclk,
    input wire logic reset,
    input wire logic hselReg,
    input wire logic hselArray,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic coreHalted,
    input wire logic debugAccess,
    input wire logic ramDebugBlock
);
    // ****************************************
    // Transfer decode
    // ****************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire logic takeAny = hready && htrans[1] && (hselReg || hselArray);
    wire logic takeReg = takeAny && hselReg;
    wire logic takeArr = takeAny && hselArray && !hwrite;
    wire logic lock = ramDebugBlock && coreHalted;
    property p_reg_wait;
        takeReg |=> !hreadyout ##1 (hreadyout && !hresp);
    endproperty
    a_reg_wait: assert property (p_reg_wait)
        else $error("register access timing wrong");
    property p_arr_wait;
        takeArr |=> !hreadyout ##1 !hreadyout;
    endproperty
    a_arr_wait: assert property (p_arr_wait)
        else $error("array read too short");
    property p_no_err;
        takeArr && !(lock && debugAccess) |=> !hresp [*3];
    endproperty
    a_no_err: assert property (p_no_err)
        else $error("error on allowed read");
    property p_err_two;
        takeArr && lock && debugAccess |->
            ##[1:3] (hresp && !hreadyout) ##1 (hresp && hreadyout);
    endproperty
    a_err_two: assert property (p_err_two)
        else $error("missing error response");
    property p_err_cause;
        hresp |-> lock ##1 (!hresp || hreadyout);
    endproperty
    a_err_cause: assert property (p_err_cause)
        else $error("error without protection");
    property p_zero;
        takeArr && lock |-> ##[2:4] (hreadyout && hrdata == 32'h0);
    endproperty
    a_zero: assert property (p_zero)
        else $error("protected read not zero");
    property p_hold;
        hreadyout && $past(hreadyout) |-> $stable(hrdata);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read data moved while idle");
    property p_idle;
        !takeAny && hreadyout |=> hreadyout;
    endproperty
    a_idle: assert property (p_idle)
        else $error("wait state without transfer");
    c_reg: cover property (takeReg);
    c_lock: cover property (takeArr && lock);
    c_err: cover property (hresp && hreadyout);
endmodule // efc_props
bind efc_flash_ctrl efc_props i_efc_props (.mclk, .reset, .hselReg,
    .hselArray, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .coreHalted, .debugAccess,
    .ramDebugBlock);
`default_nettype wire

// File: verification/efc_ahb_master.sv
// Bus master model standing in for the processor core
`timescale 1ns/1ps
`default_nettype none
module efc_ahb_master (
    input wire logic mclk,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    output logic hselReg,
    output logic hselArray,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Idle bus at time zero, word size only
    initial begin
        {hselReg, hselArray, hwrite, htrans} = 5'h00;
        haddr = 32'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // One transfer; data held until ready, then scrambled
    task automatic xfer(input logic arr, wr, input logic [31:0] a, wd,
        output logic [31:0] rd, output logic err, to);
        int n;
        @(posedge mclk);
        #1 {hselReg, hselArray, hwrite} = {!arr, arr, wr};
        haddr = a;
        htrans = 2'h2;
        @(posedge mclk);
        #1 {hselReg, hselArray, htrans} = 4'h0;
        hwdata = wd;
        n = 0;
        @(posedge mclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        rd = hrdata;
        err = hresp;
        to = (n == 50);
        // Stale data would hide a late sample
        #1 hwdata = ~wd;
    endtask
endmodule // efc_ahb_master
`default_nettype wire

// File: verification/embedded_flash_controller_bench.sv
// Self-checking bench for the flash controller
`timescale 1ns/1ps
`default_nettype none
`include "efc_consts.vh"
module embedded_flash_controller_bench;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic coreHalted = 1'b0;
    logic debugAccess = 1'b0;
    logic hselReg, hselArray, hwrite, hreadyout, hresp, ramDebugBlock;
    logic [31:0] haddr, hwdata, hrdata, rd, sig;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic err, to;
    logic [31:0] img [0:40959];
    int fails = 0;
    int checks = 0;
    always #4 mclk = ~mclk;
    efc_flash_ctrl i_efc_flash_ctrl (.mclk, .reset, .hselReg, .hselArray,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .coreHalted, .debugAccess,
        .ramDebugBlock);
    efc_ahb_master i_efc_ahb_master (.mclk, .hreadyout, .hrdata, .hresp,
        .hselReg, .hselArray, .haddr, .htrans, .hwrite, .hsize, .hwdata);
    task automatic print_verdict;
        if (fails == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic acc(input logic arr, wr, input logic [31:0] a, wd);
        i_efc_ahb_master.xfer(arr, wr, a, wd, rd, err, to);
        if (to) begin
            fails++;
            print_verdict();
        end
    endtask
    task automatic wreg(input logic [7:0] ofs, input logic [31:0] v);
        acc(1'b0, 1'b1, {24'h0, ofs}, v);
    endtask
    task automatic rreg(input logic [7:0] ofs, input logic [31:0] exp);
        acc(1'b0, 1'b0, {24'h0, ofs}, 32'h0);
        check($sformatf("reg %h", ofs), rd, exp);
    endtask
    task automatic rarr(input logic [15:0] w);
        acc(1'b1, 1'b0, {14'h0, w, 2'h0}, 32'h0);
        check($sformatf("word %h", w), rd, img[w]);
    endtask
    // Poll raw status for a flag, then clear it by writing one
    task automatic wflag(input int b);
        int n;
        n = 0;
        do begin
            acc(1'b0, 1'b0, {24'h0, `EFC_OFS_RAW}, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 25000);
        check($sformatf("flag %0d", b), {31'h0, rd[b]}, 32'h1);
        if (rd[b] !== 1'b1) print_verdict();
        wreg(`EFC_OFS_STATUS, 32'h1 << b);
    endtask
    task automatic cmd(input logic [7:0] c);
        wreg(`EFC_OFS_COMMAND, {24'h0, c});
        wflag(1);
        wflag(0);
    endtask
    initial begin
        for (int k = 0; k < 40960; k++) begin
            img[k] = 32'hFFFFFFFF;
            i_efc_flash_ctrl.uArray.cells[k] = img[k];
        end
        repeat (10) @(posedge mclk);
        #1 reset = 1'b0;
        repeat (10) @(posedge mclk);
        rreg(`EFC_OFS_ENABLE, 32'h3F);
        rreg(`EFC_OFS_SIGN, 32'hFFFFFFFF);
        rreg(`EFC_OFS_RAW, 32'h0);
        check("lock", {31'h0, ramDebugBlock}, 32'h0);
        // Second program of one word can only clear more bits
        wreg(`EFC_OFS_PADDR, 32'h2A45);
        wreg(`EFC_OFS_BURST_WORD_FIRST, 32'h12345678);
        cmd(`EFC_CMD_WRITE);
        wreg(`EFC_OFS_BURST_WORD_FIRST, 32'hF0F0F0F0);
        cmd(`EFC_CMD_WRITE);
        img[16'h2A45] = 32'h10305070;
        rarr(16'h2A45);
        // Quad across a row boundary, last word padded with ones
        wreg(`EFC_OFS_PADDR, 32'h023E);
        for (int k = 0; k < 4; k++) begin
            img[16'h023E + k] = {4{8'hA5 ^ k[7:0]}} | {32{k == 3}};
            wreg(`EFC_OFS_BURST_WORD_FIRST + 8'(4 * k), img[16'h023E + k]);
        end
        cmd(`EFC_CMD_QUAD);
        for (int k = 0; k < 6; k++) rarr(16'h023D + k);
        // Page erase with a command colliding while it runs
        wreg(`EFC_OFS_PADDR, 32'h0200);
        wreg(`EFC_OFS_COMMAND, 32'h11);
        wreg(`EFC_OFS_COMMAND, 32'h33);
        wflag(1);
        wflag(0);
        for (int k = 16'h200; k < 16'h400; k++) img[k] = 32'hFFFFFFFF;
        rreg(`EFC_OFS_RAW, 32'h4);
        wreg(`EFC_OFS_ENABLE, 32'h3B);
        rreg(`EFC_OFS_STATUS, 32'h0);
        wreg(`EFC_OFS_RAW, 32'h4);
        wreg(`EFC_OFS_ENABLE, 32'h3F);
        wreg(`EFC_OFS_COMMAND, 32'h77);
        rreg(`EFC_OFS_RAW, 32'h8);
        wreg(`EFC_OFS_RAW, 32'h8);
        for (int k = 0; k < 6; k++) rarr(16'h023D + k);
        rarr(16'h0200);
        // Scan: one differing word, so no match flag
        wreg(`EFC_OFS_BURST_WORD_FIRST, 32'hFFFFFFFF);
        cmd(`EFC_CMD_SCAN);
        sig = 32'hFFFFFFFF;
        for (int k = 0; k < 40960; k++)
            sig = (sig << 1) ^ (sig[31] ? 32'h8000001B : 32'h0) ^ img[k];
        rreg(`EFC_OFS_SIGN, sig);
        rreg(`EFC_OFS_RAW, 32'h0);
        // Arm protection through the last word pair
        wreg(`EFC_OFS_PADDR, 32'h9FFE);
        wreg(`EFC_OFS_BURST_WORD_FIRST, 32'h0);
        cmd(`EFC_CMD_WRITE);
        check("lock", {31'h0, ramDebugBlock}, 32'h1);
        coreHalted = 1'b1;
        debugAccess = 1'b1;
        acc(1'b1, 1'b0, 32'h2A45 << 2, 32'h0);
        check("locked data", rd, 32'h0);
        check("locked resp", {31'h0, err}, 32'h1);
        coreHalted = 1'b0;
        rarr(16'h2A45);
        print_verdict();
    end
endmodule // embedded_flash_controller_bench
`default_nettype wire
